// >>> rtl/wfmd_pkg.sv
package wfmd_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_FILTER_PORT = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_STATION_LO  = 8'h08;
  localparam logic [7:0]  ADDR_STATION_HI  = 8'h0C;
  localparam logic [7:0]  ADDR_FILTER_PTR  = 8'h10;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // ---------------------------------------------------------------
  // control/status fields
  // ---------------------------------------------------------------
  localparam int CS_MAGIC_EN    = 0;
  localparam int CS_PATTERN_EN  = 1;
  localparam int CS_MAGIC_SEEN  = 2;
  localparam int CS_PATTERN_SEEN = 3;
  localparam int CS_USE_PME     = 4;
  localparam int CS_BROADCAST_REJECT_REJ   = 5;
  localparam int CS_LOW_POWER   = 6;
  localparam int CS_WIDTH       = 7;
  // ---------------------------------------------------------------
  // filter store layout
  // ---------------------------------------------------------------
  localparam int                FILTERS       = 4;
  localparam int                STORE_WORDS   = 8;
  localparam logic [2:0]        WORD_CMD      = 3'h4;
  localparam logic [2:0]        WORD_OFFSET   = 3'h5;
  localparam logic [2:0]        WORD_CRC_LO   = 3'h6;
  localparam logic [2:0]        WORD_CRC_HI   = 3'h7;
  localparam logic [2:0]        WORD_LAST     = 3'h7;
  localparam int                CMD_ENABLE    = 0;
  localparam int                CMD_MCAST     = 3;
  localparam logic [4:0]        MASK_BITS     = 5'h1F;
  localparam logic [15:0]       CRC16_INIT    = 16'hFFFF;
  localparam logic [15:0]       CRC16_POLY    = 16'h8005;
  // ---------------------------------------------------------------
  // magic packet
  // ---------------------------------------------------------------
  localparam logic [7:0]  SYNC_BYTE   = 8'hFF;
  localparam logic [2:0]  SYNC_LEN    = 3'h6;
  localparam logic [2:0]  ADDR_LEN    = 3'h6;
  localparam logic [4:0]  ADDR_COPIES = 5'h10;
  localparam logic [3:0]  HDR_LEN     = 4'hC;
  typedef enum logic [1:0] {
    WFMD_MG_SYNC = 2'b00,
    WFMD_MG_COPY = 2'b01,
    WFMD_MG_DONE = 2'b10
  } wfmd_magic_e;
endpackage : wfmd_pkg

// >>> rtl/wfmd_store_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wfmd_store_if;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [31:0] wr_data;
  logic [2:0]  rd_addr;
  logic [31:0] rd_data;
  logic [31:0] words [8];
  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data, input words);
  modport mem   (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data, output words);
endinterface : wfmd_store_if
`default_nettype wire

// >>> rtl/wfmd_filter_store.sv
`timescale 1ns/10ps
`default_nettype none
module wfmd_filter_store
  import wfmd_pkg::*;
(
  input wire logic    aclk,
  input wire logic    aresetn,
  wfmd_store_if.mem   st
);
  logic [31:0] mem [STORE_WORDS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < STORE_WORDS; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else if (st.wr_en) begin
      mem[st.wr_addr] <= st.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.rd_data <= 32'h0000_0000;
    end else begin
      st.rd_data <= mem[st.rd_addr];
    end
  end

  always_comb begin
    for (int i = 0; i < STORE_WORDS; i++) begin
      st.words[i] = mem[i];
    end
  end
endmodule : wfmd_filter_store
`default_nettype wire

// >>> rtl/wfmd_top.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - mask bit j set includes byte offset+j; bits 30..0 used, bit 31 ignored
// - command bit 3 picks multicast-only, clear picks unicast-only
// - command bit 0 enables a filter; bits 2..1 reserved
// - byte 0 is first destination byte; crc starts at offset
// - masked crc-16 equal to stored value means wake frame
// - store: four masks, commands, offsets, two crc pair words
// - magic mode blocks normal reception, watches only magic packets
// - magic detection reported on interrupt or power event, selectable
// - magic detection sets magic seen status bit
// - clearing magic enable resumes normal reception unless pattern enable or low power is set
// - own, broadcast or multicast destinations checked for magic
// - after the addresses, search for six 0xFF bytes
// - sixteen unbroken station address copies after sync declare magic
// - broken run drops partial match, sync search restarts
// - sync plus copies anywhere, copies must follow sync directly
// - low-power state forces both detectors on
// - pattern enable blocks normal reception; match sets pattern seen
// - broadcast wake frame matches even with broadcast rejected
module wfmd_top
  import wfmd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  output var  logic        rx_normal_enable,
  output var  logic        irq_out,
  output var  logic        power_event_out
);
  import wfmd_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      if (r[15] ^ d[b]) begin
        r = {r[14:0], 1'b0} ^ CRC16_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc16_byte

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        r[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wfmd_store_if st ();

  logic [CS_WIDTH-1:0] wake_ctrl_status;
  logic [47:0]         station_addr;
  logic [2:0]          word_ptr;
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                rd_pend;
  logic                rd_port;
  logic                wr_go;
  logic                rd_go;
  logic                magic_hit;
  logic                pattern_hit;
  logic                magic_active;
  logic                pattern_active;

  wfmd_filter_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .st      (st.mem)
  );

  assign magic_active   = wake_ctrl_status[CS_MAGIC_EN] | wake_ctrl_status[CS_LOW_POWER];
  assign pattern_active = wake_ctrl_status[CS_PATTERN_EN] | wake_ctrl_status[CS_LOW_POWER];

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          ADDR_FILTER_PORT, ADDR_CTRL_STATUS, ADDR_STATION_LO, ADDR_STATION_HI,
          ADDR_FILTER_PTR: s_axi_bresp <= RESP_OKAY;
          default:         s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // store writes go through the single port at the current pointer
  always_comb begin
    st.wr_en   = wr_go && (aw_addr == ADDR_FILTER_PORT);
    st.wr_addr = word_ptr;
    st.wr_data = merge_strb(st.words[word_ptr], w_data, w_strb);
    st.rd_addr = word_ptr;
  end

  // pointer moves after each port access, wraps after last word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_ptr <= 3'h0;
    end else if (wr_go && aw_addr == ADDR_FILTER_PTR && w_strb[0]) begin
      word_ptr <= w_data[2:0];
    end else if (st.wr_en || (rd_go && s_axi_araddr == ADDR_FILTER_PORT)) begin
      word_ptr <= (word_ptr == WORD_LAST) ? 3'h0 : word_ptr + 3'h1;
    end
  end

  // control bits; hardware set of seen flags wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_ctrl_status <= '0;
    end else begin
      if (wr_go && aw_addr == ADDR_CTRL_STATUS && w_strb[0]) begin
        wake_ctrl_status[CS_MAGIC_EN]   <= w_data[CS_MAGIC_EN];
        wake_ctrl_status[CS_PATTERN_EN] <= w_data[CS_PATTERN_EN];
        wake_ctrl_status[CS_USE_PME]    <= w_data[CS_USE_PME];
        wake_ctrl_status[CS_BROADCAST_REJECT_REJ]  <= w_data[CS_BROADCAST_REJECT_REJ];
        wake_ctrl_status[CS_LOW_POWER]  <= w_data[CS_LOW_POWER];
        if (w_data[CS_MAGIC_SEEN]) begin
          wake_ctrl_status[CS_MAGIC_SEEN] <= 1'b0;
        end
        if (w_data[CS_PATTERN_SEEN]) begin
          wake_ctrl_status[CS_PATTERN_SEEN] <= 1'b0;
        end
      end
      if (magic_hit) begin
        wake_ctrl_status[CS_MAGIC_SEEN] <= 1'b1;
      end
      if (pattern_hit) begin
        wake_ctrl_status[CS_PATTERN_SEEN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      station_addr <= 48'h0000_0000_0000;
    end else if (wr_go && aw_addr == ADDR_STATION_LO) begin
      station_addr[31:0] <= merge_strb(station_addr[31:0], w_data, w_strb);
    end else if (wr_go && aw_addr == ADDR_STATION_HI) begin
      station_addr[47:32] <= 16'(merge_strb({16'h0000, station_addr[47:32]}, w_data, w_strb));
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      rd_pend       <= 1'b0;
      rd_port       <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_pend && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        rd_pend       <= 1'b1;
        rd_port       <= (s_axi_araddr == ADDR_FILTER_PORT);
        s_axi_rresp   <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_FILTER_PORT: s_axi_rdata <= 32'h0000_0000;
          ADDR_CTRL_STATUS: s_axi_rdata <= {{(32-CS_WIDTH){1'b0}}, wake_ctrl_status};
          ADDR_STATION_LO:  s_axi_rdata <= station_addr[31:0];
          ADDR_STATION_HI:  s_axi_rdata <= {16'h0000, station_addr[47:32]};
          ADDR_FILTER_PTR:  s_axi_rdata <= {29'h0000_0000, word_ptr};
          default: begin
            s_axi_rdata <= UNMAPPED_DATA;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (rd_port) begin
          s_axi_rdata <= st.rd_data;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive byte position and destination class
  // ---------------------------------------------------------------
  logic [10:0] byte_pos;
  logic [47:0] dest_addr;
  logic        dest_mcast;
  logic        dest_broadcast_reject;
  logic        dest_own;
  logic        in_frame;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_pos  <= 11'h000;
      dest_addr <= 48'h0000_0000_0000;
      in_frame  <= 1'b0;
    end else if (rx_valid) begin
      in_frame <= !rx_eof;
      byte_pos <= rx_sof ? 11'h001 : byte_pos + 11'h001;
      if (rx_sof) begin
        dest_addr <= {rx_data, 40'h00_0000_0000};
      end else if (byte_pos < 11'(ADDR_LEN)) begin
        dest_addr[47 - byte_pos*8 -: 8] <= rx_data;
      end
    end
  end

  assign dest_mcast = dest_addr[40];
  assign dest_broadcast_reject = &dest_addr;
  assign dest_own   = (dest_addr == station_addr);
  logic [10:0] cur_pos;
  assign cur_pos = rx_sof ? 11'h000 : byte_pos;

  // ---------------------------------------------------------------
  // wake pattern filters
  // ---------------------------------------------------------------
  logic [15:0] crc_acc [FILTERS];
  logic [3:0]  hit_vec;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int f = 0; f < FILTERS; f++) begin
        crc_acc[f] <= CRC16_INIT;
      end
    end else if (rx_valid) begin
      for (int f = 0; f < FILTERS; f++) begin
        logic [15:0] base;
        logic [10:0] rel;
        logic [7:0]  ofs;
        base = rx_sof ? CRC16_INIT : crc_acc[f];
        ofs  = st.words[WORD_OFFSET][f*8 +: 8];
        rel  = cur_pos - {3'h0, ofs};
        if (cur_pos >= {3'h0, ofs} && rel < 11'(MASK_BITS) &&
            st.words[f][rel[4:0]]) begin
          crc_acc[f] <= crc16_byte(base, rx_data);
        end else begin
          crc_acc[f] <= base;
        end
      end
    end
  end

  // evaluated on the final byte; masks reaching past the last byte use the crc so far
  always_comb begin
    for (int f = 0; f < FILTERS; f++) begin
      logic [7:0]  cmd;
      logic [15:0] want;
      logic        class_ok;
      cmd  = st.words[WORD_CMD][f*8 +: 8];
      want = (f < 2) ? st.words[WORD_CRC_LO][(f%2)*16 +: 16]
                     : st.words[WORD_CRC_HI][(f%2)*16 +: 16];
      class_ok = cmd[CMD_MCAST] ? dest_mcast : !dest_mcast;
      hit_vec[f] = cmd[CMD_ENABLE] && class_ok && (crc_acc[f] == want);
    end
  end

  // ---------------------------------------------------------------
  // magic packet search
  // ---------------------------------------------------------------
  wfmd_magic_e magic_state;
  logic [2:0]  run_cnt;
  logic [4:0]  copy_cnt;
  logic [7:0]  expect_byte;
  logic        magic_dest_ok;

  assign expect_byte   = station_addr[47 - run_cnt*8 -: 8];
  assign magic_dest_ok = dest_own || dest_broadcast_reject || dest_mcast;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      magic_state <= WFMD_MG_SYNC;
      run_cnt     <= 3'h0;
      copy_cnt    <= 5'h00;
    end else if (rx_valid && rx_sof) begin
      magic_state <= WFMD_MG_SYNC;
      run_cnt     <= 3'h0;
      copy_cnt    <= 5'h00;
    end else if (rx_valid && cur_pos >= 11'(HDR_LEN)) begin
      case (magic_state)
        WFMD_MG_SYNC: begin
          if (rx_data == SYNC_BYTE) begin
            if (run_cnt == SYNC_LEN - 3'h1) begin
              magic_state <= WFMD_MG_COPY;
              run_cnt     <= 3'h0;
              copy_cnt    <= 5'h00;
            end else begin
              run_cnt <= run_cnt + 3'h1;
            end
          end else begin
            run_cnt <= 3'h0;
          end
        end
        WFMD_MG_COPY: begin
          if (rx_data == expect_byte) begin
            if (run_cnt == ADDR_LEN - 3'h1) begin
              run_cnt <= 3'h0;
              if (copy_cnt == ADDR_COPIES - 5'h01) begin
                magic_state <= WFMD_MG_DONE;
              end else begin
                copy_cnt <= copy_cnt + 5'h01;
              end
            end else begin
              run_cnt <= run_cnt + 3'h1;
            end
          end else if (rx_data == SYNC_BYTE) begin
            // extra ff bytes keep the sync window open
            magic_state <= (run_cnt == 3'h0 && copy_cnt == 5'h00) ? WFMD_MG_COPY
                                                                  : WFMD_MG_SYNC;
            run_cnt     <= (run_cnt == 3'h0 && copy_cnt == 5'h00) ? 3'h0 : 3'h1;
            copy_cnt    <= 5'h00;
          end else begin
            magic_state <= WFMD_MG_SYNC;
            run_cnt     <= 3'h0;
            copy_cnt    <= 5'h00;
          end
        end
        WFMD_MG_DONE: magic_state <= WFMD_MG_DONE;
        default:      magic_state <= WFMD_MG_SYNC;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame end decisions and notification
  // ---------------------------------------------------------------
  assign magic_hit   = rx_valid && rx_eof && magic_active && magic_dest_ok &&
                       (magic_state == WFMD_MG_DONE);
  // broadcast reject is not consulted here on purpose
  assign pattern_hit = rx_valid && rx_eof && pattern_active && (|hit_vec);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_normal_enable <= 1'b1;
    end else begin
      rx_normal_enable <= !(magic_active || pattern_active);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out         <= 1'b0;
      power_event_out <= 1'b0;
    end else begin
      irq_out <= !wake_ctrl_status[CS_USE_PME] &&
                 (wake_ctrl_status[CS_MAGIC_SEEN] || wake_ctrl_status[CS_PATTERN_SEEN]);
      power_event_out <= wake_ctrl_status[CS_USE_PME] &&
                 (wake_ctrl_status[CS_MAGIC_SEEN] || wake_ctrl_status[CS_PATTERN_SEEN]);
    end
  end

endmodule : wfmd_top
`default_nettype wire

// >>> testbench/wfmd_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module wfmd_top_sva
  import wfmd_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_valid,
  input wire logic        rx_eof,
  input wire logic        rx_normal_enable,
  input wire logic        irq_out,
  input wire logic        power_event_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_recent_write;
    $past(s_axi_wvalid, 1) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endsequence
  sequence s_wake_cause;
    $past(rx_valid && rx_eof, 1) || $past(rx_valid && rx_eof, 2) || $past(s_axi_wvalid, 1)
      || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endsequence
  a_rd_latency: assert property (s_ar_take |-> ##[1:2] s_axi_rvalid)
    else $error("read answer missing");
  a_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_wr_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_unmapped_err: assert property ((s_ar_take and (s_axi_araddr > ADDR_FILTER_PTR)) |-> ##[1:2]
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == UNMAPPED_DATA)
    else $error("unmapped read not refused");
  a_route_excl: assert property (!(irq_out && power_event_out))
    else $error("both wake outputs high");
  a_wake_cause: assert property ($rose(irq_out) || $rose(power_event_out) |-> s_wake_cause)
    else $error("wake output without cause");
  a_rx_gate: assert property ($changed(rx_normal_enable) |-> s_recent_write)
    else $error("reception gate moved without write");
endmodule : wfmd_top_sva
bind wfmd_top wfmd_top_sva i_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_eof,
  .rx_normal_enable, .irq_out, .power_event_out
);
`default_nettype wire

// >>> testbench/wfmd_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module wfmd_link_partner (
  input  wire logic       aclk,
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  output var  logic       rx_sof,
  output var  logic       rx_eof
);
  integer seed = 32'h5F20;
  initial {rx_data, rx_valid, rx_sof, rx_eof} = '0;
  // idle bytes show the inverse of the last one, but after a gap on the final byte the closing idle shows that byte unchanged
  task automatic send_frame(input logic [7:0] f[$], input bit slow);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge aclk);
      rx_data  <= f[i];
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_eof   <= (i == f.size() - 1);
      if (slow && $random(seed) % 2) begin
        @(posedge aclk);
        {rx_valid, rx_sof, rx_eof} <= '0;
        rx_data  <= ~f[i];
      end
    end
    @(posedge aclk);
    {rx_valid, rx_sof, rx_eof} <= '0;
    rx_data <= ~rx_data;
  endtask : send_frame
endmodule : wfmd_link_partner
`default_nettype wire

// >>> testbench/test_wfmd_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_wfmd_top;
  import wfmd_pkg::*;
  logic        aclk, aresetn, rx_valid, rx_sof, rx_eof, rx_normal_enable, irq_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, power_event_out;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, offs;
  logic [31:0] s_axi_wdata, s_axi_rdata, mask, words[8];
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] crc;
  logic [47:0] station, dst[4];
  logic [33:0] exp_q[$];
  logic [7:0]  frm[$];
  integer      seed = 32'h5F20, bad_count = 0, n_compared = 0;
  localparam logic [3:0] CMDS[4] = '{4'h1, 4'h9, 4'h6, 4'h9};
  localparam logic [3:0] HIT = 4'b0011;
  wfmd_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_data, .rx_valid, .rx_sof, .rx_eof, .rx_normal_enable, .irq_out,
    .power_event_out);
  wfmd_link_partner i_lp (.aclk, .rx_data, .rx_valid, .rx_sof, .rx_eof);
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    exp_q.push_back(exp);
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  always @(posedge aclk)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction : crc16
  task automatic make_frame(input logic [47:0] d);
    frm = {};
    for (int i = 0; i < 6; i++) frm.push_back(d[47 - 8 * i -: 8]);
    repeat (46) frm.push_back(8'($random(seed)));
  endtask : make_frame
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL_STATUS, {RESP_OKAY, 32'h0});
    rd(8'h40, {RESP_SLVERR, UNMAPPED_DATA});
    station = {$random(seed), $random(seed)} & 48'hFEFF_FFFF_FFFF;
    wr(ADDR_STATION_LO, station[31:0]);
    wr(ADDR_STATION_HI, {16'h0, station[47:32]});
    dst = '{station, 48'hFFFF_FFFF_FFFF, station, station};
    mask = $random(seed) & 32'h7FFF_FFFF;
    offs = 8'd12 + 8'($random(seed) & 7);
    for (int k = 0; k < 4; k++) begin
      make_frame(dst[k]);
      crc = CRC16_INIT;
      for (int j = 0; j < 31; j++) if (mask[j]) crc = crc16(crc, frm[offs + j]);
      words = '{mask, mask, mask, mask, 32'(CMDS[k]) << (8 * k), {4{offs}}, {2{crc}}, {2{crc}}};
      wr(ADDR_FILTER_PTR, 32'h0);
      foreach (words[i]) wr(ADDR_FILTER_PORT, words[i]);
      if (k == 0) foreach (words[i]) rd(ADDR_FILTER_PORT, {RESP_OKAY, words[i]});
      rd(ADDR_FILTER_PTR, {RESP_OKAY, 32'h0});
      wr(ADDR_CTRL_STATUS, 32'h22);
      i_lp.send_frame(frm, k[0]);
      repeat (4) @(posedge aclk);
      rd(ADDR_CTRL_STATUS, {RESP_OKAY, 32'h22 | (32'(HIT[k]) << 3)});
      wr(ADDR_CTRL_STATUS, 32'h08);
    end
    make_frame(station);
    for (int r = 0; r < 2; r++) begin
      repeat (6) frm.push_back(SYNC_BYTE);
      for (int c = 0; c < 15 + r; c++)
        for (int i = 0; i < 6; i++) frm.push_back(station[47 - 8 * i -: 8]);
      frm.push_back(8'h00);
      wr(ADDR_CTRL_STATUS, 32'h11);
      repeat (2) @(posedge aclk);
      check("rx gate", rx_normal_enable, 0);
      i_lp.send_frame(frm, 1'b1);
      repeat (4) @(posedge aclk);
      rd(ADDR_CTRL_STATUS, {RESP_OKAY, 32'h11 | (32'(r) << 2)});
    end
    check("route", {irq_out, power_event_out}, 2'b01);
    wr(ADDR_CTRL_STATUS, 32'h01);
    repeat (3) @(posedge aclk);
    check("route", {irq_out, power_event_out}, 2'b10);
    wr(ADDR_CTRL_STATUS, 32'h04);
    repeat (3) @(posedge aclk);
    check("rx gate", rx_normal_enable, 1);
    wr(ADDR_CTRL_STATUS, 32'h40);
    i_lp.send_frame(frm, 1'b0);
    repeat (4) @(posedge aclk);
    rd(ADDR_CTRL_STATUS, {RESP_OKAY, 32'h44});
    report_and_stop();
  end
  initial begin
    repeat (50000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
endmodule : test_wfmd_top
`default_nettype wire
